//--- design/odc_pkg.sv
// package: register layout, reset values and timing for output driver control
package odc_pkg;

  // ****************************************************************
  // register selection and layout
  // ****************************************************************
  localparam logic       SEL_OUT_EC    = 1'h0;     // first control word
  localparam logic       SEL_RECOV_PWM = 1'h1;     // second control word
  localparam int         REF_MSB       = 7;        // reference code msb
  localparam int         REF_LSB       = 2;        // reference code lsb
  localparam int         EC_MODE_BIT   = 1;        // electrochrome mode switch
  localparam int         HIGHSIDE_OUTPUT_TEN_ON_BIT  = 10;       // highside ten on/off
  localparam int         ECV_ON_BIT    = 8;        // sense output lowside on/off
  localparam int         RECOV_MSB     = 15;       // half bridge one recovery
  localparam int         RECOV_LSB     = 10;       // half bridge six recovery
  localparam int         ECV_RECOV_BIT = 9;        // sense output recovery
  localparam int         PWM_EN_MSB    = 7;        // half bridge one pwm gate
  localparam int         PWM_EN_LSB    = 2;        // half bridge six pwm gate
  localparam int         ECV_PWM_BIT   = 1;        // sense output pwm gate
  localparam int         FS_SEL_BIT    = 0;        // high full scale select
  localparam logic [15:0] W1_RSVD_MASK = 16'hFFFE; // bit 0 reserved
  localparam logic [15:0] W2_RSVD_MASK = 16'hFEFF; // bit 8 reserved
  localparam logic [15:0] W1_RESET     = 16'h0000; // first word after reset
  localparam logic [15:0] W2_RESET     = 16'h0000; // full scale select at 0
  localparam logic [5:0]  HB_PWM_B_MAP = 6'h10;    // half bridge five on pwm b
  localparam int         NUM_CH        = 7;        // six half bridges plus sense

  // ****************************************************************
  // recovery timing
  // ****************************************************************
  localparam int CLK_HZ          = 40000000;         // 40 MHz system clock
  localparam int OCR_SLOW_HZ10   = 17;               // 1.7 kHz, tenths of kHz
  localparam int OCR_FAST_HZ10   = 30;               // 3 kHz, tenths of kHz
  localparam int OCR_SLOW_CYC    = CLK_HZ / (OCR_SLOW_HZ10 * 100); // longest: floor
  localparam int OCR_FAST_CYC    = CLK_HZ / (OCR_FAST_HZ10 * 100);
  localparam int OCR_CNT_W       = 15;               // holds 23529

endpackage : odc_pkg

//--- design/odc_ocr_if.sv
// interface: one over-current recovery channel between top and channel logic
`timescale 1ns/1ps
interface odc_ocr_if;
  logic event_p;    // over-current event pulse
  logic recov_en;   // effective recovery enable
  logic tick;       // recovery period boundary pulse
  logic late;       // event lands in second half of period
  logic clr;        // clear status flag pulse
  logic flag;       // sticky over-current status
  logic allow;      // channel may drive

  modport top (output event_p, recov_en, tick, late, clr, input flag, allow);
  modport chan (input event_p, recov_en, tick, late, clr, output flag, allow);
endinterface : odc_ocr_if

//--- design/odc_ocr_chan.sv
// module: over-current shutdown and recovery for one output channel
`timescale 1ns/1ps
module odc_ocr_chan
(
  input  wire logic clk_in,      // system clock
  input  wire logic sys_rst_in,  // synchronous reset, active high
  odc_ocr_if.chan   ch           // channel control
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {ODC_RUN, ODC_WAIT, ODC_LATCH} odc_ocr_st_t;
  odc_ocr_st_t st_r, st_nxt;       // channel state
  logic        flag_r, flag_nxt;   // sticky status
  logic        used_r, used_nxt;   // one unrequested recovery spent

  // one-shot only when disabled and the phase was late
  wire logic   one_shot = ~ch.recov_en & ch.late & ~used_r;

  // next state; event in run switches output off
  always_comb
  begin
    st_nxt   = st_r;
    used_nxt = used_r & ~ch.clr;
    unique case (st_r)
      ODC_RUN:
      begin
        if (ch.event_p)
        begin
          if (ch.recov_en | one_shot) st_nxt = ODC_WAIT;
          else                        st_nxt = ODC_LATCH;
          if (one_shot) used_nxt = 1'b1;
        end
      end
      ODC_WAIT:
      begin
        if (ch.tick) st_nxt = ODC_RUN;
      end
      ODC_LATCH:
      begin
        if (ch.clr) st_nxt = ODC_RUN;  // software restart
      end
    endcase
  end

  // set beats clear so a coincident event is never lost
  assign flag_nxt = ch.event_p | (flag_r & ~ch.clr);

  // state registers
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      st_r   <= ODC_RUN;
      flag_r <= 1'b0;
      used_r <= 1'b0;
    end
    else
    begin
      st_r   <= st_nxt;
      flag_r <= flag_nxt;
      used_r <= used_nxt;
    end
  end

  assign ch.flag  = flag_r;
  assign ch.allow = (st_r == ODC_RUN);

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_hit_run;
    ch.event_p && st_r == ODC_RUN;
  endsequence

  a_event_sets_flag: assert property (ch.event_p |=> flag_r)
    else $error("event did not set status flag");
  a_event_drops_out: assert property (s_hit_run |=> !ch.allow)
    else $error("output not switched off on event");
  a_recov_waits: assert property (s_hit_run ##0 ch.recov_en |=> st_r == ODC_WAIT)
    else $error("enabled recovery did not start waiting");
  a_no_recov_latch: assert property (s_hit_run ##0 !ch.recov_en && (!ch.late || used_r)
      |=> st_r == ODC_LATCH)
    else $error("disabled recovery did not latch off");
endmodule // odc_ocr_chan

//--- design/odc_ctrl_top.sv
// module: output driver control words, pwm gating and over-current recovery
`timescale 1ns/1ps
// Overview of operation
// - first word bits 7:2 give reference code
// - reference code plain unsigned, bit 7 msb
// - mode bit enables electrochrome gate drive
// - mode bit forces highside ten on
// - over-current sets flag, switches output off
// - recovery enable re-activates output after delay
// - one recovery possible even when disabled
// - mode bit disables sense output recovery
// - second word holds pwm gate enables
// - gated output follows its pwm input
// - five and ten on pwm b
// - select bit chooses 1.2V or 1.5V
// - full scale select resets to zero
module odc_ctrl_top
#(
  parameter int OCR_SLOW_CYC = odc_pkg::OCR_SLOW_CYC, // slow recovery period
  parameter int OCR_FAST_CYC = odc_pkg::OCR_FAST_CYC  // fast recovery period
)
(
  input  wire logic        clk_in,            // 40 MHz clock
  input  wire logic        sys_rst_in,        // synchronous reset
  input  wire logic        wr_en_in,          // write strobe from serial port
  input  wire logic        wr_sel_in,         // 0 first word, 1 second word
  input  wire logic [15:0] wr_data_in,        // write data
  input  wire logic [5:0]  hb_on_in,          // half bridge on/off bits, one at 0
  input  wire logic        highside_output_ten_pwm_en_in,   // highside ten pwm gate enable
  input  wire logic        ocr_fast_in,       // recovery frequency select
  input  wire logic        pwm_a_in,          // pwm_input_a
  input  wire logic        pwm_b_in,          // pwm_input_b
  input  wire logic [6:0]  oc_event_in,       // over-current pulses, 6 is sense
  input  wire logic [6:0]  oc_clr_in,         // status clear pulses
  output logic      [15:0] word1_out,         // first word readback
  output logic      [15:0] word2_out,         // second word readback
  output logic      [5:0]  ec_ref_code_out,   // converter target
  output logic             ec_gate_drive_out, // external transistor drive
  output logic             full_scale_hi_out, // 1 selects 1.5V, 0 selects 1.2V
  output logic      [5:0]  hb_drive_out,      // half bridge drive, one at 0
  output logic             ecv_drive_out,     // sense output lowside drive
  output logic             highside_output_ten_drive_out,   // highside ten drive
  output logic      [6:0]  oc_flag_out        // over-current status
);

  // ****************************************************************
  // control words
  // ****************************************************************
  logic [15:0] w1_r;  // output enable and electrochrome control
  logic [15:0] w2_r;  // recovery and pwm gating control

  // masking reserved bits keeps them reading zero even if misused
  wire logic w1_we = wr_en_in & (wr_sel_in == odc_pkg::SEL_OUT_EC);
  wire logic w2_we = wr_en_in & (wr_sel_in == odc_pkg::SEL_RECOV_PWM);

  // word registers
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      w1_r <= odc_pkg::W1_RESET;
      w2_r <= odc_pkg::W2_RESET;
    end
    else
    begin
      if (w1_we) w1_r <= wr_data_in & odc_pkg::W1_RSVD_MASK;
      if (w2_we) w2_r <= wr_data_in & odc_pkg::W2_RSVD_MASK;
    end
  end

  // ****************************************************************
  // field decode
  // ****************************************************************
  wire logic       ec_mode  = w1_r[odc_pkg::EC_MODE_BIT];
  wire logic [5:0] ref_code = w1_r[odc_pkg::REF_MSB:odc_pkg::REF_LSB];
  wire logic [5:0] hb_recov = w2_r[odc_pkg::RECOV_MSB:odc_pkg::RECOV_LSB];
  wire logic [5:0] hb_pwm   = w2_r[odc_pkg::PWM_EN_MSB:odc_pkg::PWM_EN_LSB];
  // sense recovery enable ignored in electrochrome mode
  wire logic       ecv_rec  = w2_r[odc_pkg::ECV_RECOV_BIT] & ~ec_mode;
  wire logic       ecv_pwm  = w2_r[odc_pkg::ECV_PWM_BIT];

  // bit fields run msb-first for output one, so reverse into index order
  function automatic logic [5:0] odc_rev6(input logic [5:0] v);
    for (int i = 0; i < 6; i++) odc_rev6[i] = v[5 - i];
  endfunction

  // gated level: pwm input passes through only when gating is enabled
  function automatic logic odc_gate(input logic on, input logic en, input logic pwm);
    odc_gate = on & (~en | pwm);
  endfunction

  wire logic [5:0] hb_recov_i = odc_rev6(hb_recov);
  wire logic [5:0] hb_pwm_i   = odc_rev6(hb_pwm);

  // ****************************************************************
  // recovery period divider
  // ****************************************************************
  logic [odc_pkg::OCR_CNT_W-1:0] per_cnt_r;  // position within period
  logic                          tick_r;     // period boundary pulse
  // one divider serves all channels, so delay depends on event phase
  wire logic [odc_pkg::OCR_CNT_W-1:0] per_len = ocr_fast_in ?
    odc_pkg::OCR_CNT_W'(OCR_FAST_CYC) : odc_pkg::OCR_CNT_W'(OCR_SLOW_CYC);
  wire logic per_end = (per_cnt_r >= per_len - odc_pkg::OCR_CNT_W'(1));
  wire logic late    = (per_cnt_r >= (per_len >> 1));

  // divider process
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      per_cnt_r <= '0;
      tick_r    <= 1'b0;
    end
    else
    begin
      per_cnt_r <= per_end ? '0 : per_cnt_r + odc_pkg::OCR_CNT_W'(1);
      tick_r    <= per_end;
    end
  end

  // ****************************************************************
  // over-current channels
  // ****************************************************************
  logic [6:0] allow;  // channel may drive
  logic [6:0] flag;   // channel status

  for (genvar g = 0; g < odc_pkg::NUM_CH; g++)
  begin : g_ch
    odc_ocr_if ocr ();
    assign ocr.event_p  = oc_event_in[g];
    assign ocr.recov_en = (g == 6) ? ecv_rec : hb_recov_i[g % 6];
    assign ocr.tick     = tick_r;
    assign ocr.late     = late;
    assign ocr.clr      = oc_clr_in[g];
    assign flag[g]      = ocr.flag;
    assign allow[g]     = ocr.allow;
    odc_ocr_chan u_chan
    (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .ch         (ocr.chan)
    );
  end

  // ****************************************************************
  // drive decisions
  // ****************************************************************
  logic [5:0] hb_nxt;  // half bridge drive next
  wire  logic [5:0] hb_pwm_src =
    (odc_pkg::HB_PWM_B_MAP & {6{pwm_b_in}}) | (~odc_pkg::HB_PWM_B_MAP & {6{pwm_a_in}});

  // half bridges gated by on bit, pwm and recovery state
  always_comb
  begin
    for (int i = 0; i < 6; i++)
      hb_nxt[i] = odc_gate(hb_on_in[i], hb_pwm_i[i], hb_pwm_src[i]) & allow[i];
  end

  wire logic ecv_nxt = odc_gate(w1_r[odc_pkg::ECV_ON_BIT], ecv_pwm, pwm_a_in)
                       & allow[6];
  // mode bit overrides the on/off bit and pwm gating
  wire logic o10_nxt = ec_mode |
                       odc_gate(w1_r[odc_pkg::HIGHSIDE_OUTPUT_TEN_ON_BIT], highside_output_ten_pwm_en_in, pwm_b_in);

  // output registers
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      hb_drive_out      <= '0;
      ecv_drive_out     <= 1'b0;
      highside_output_ten_drive_out   <= 1'b0;
      ec_gate_drive_out <= 1'b0;
      ec_ref_code_out   <= '0;
      full_scale_hi_out <= 1'b0;
      oc_flag_out       <= '0;
      word1_out         <= odc_pkg::W1_RESET;
      word2_out         <= odc_pkg::W2_RESET;
    end
    else
    begin
      hb_drive_out      <= hb_nxt;
      ecv_drive_out     <= ecv_nxt;
      highside_output_ten_drive_out   <= o10_nxt;
      ec_gate_drive_out <= ec_mode;
      ec_ref_code_out   <= ref_code;
      full_scale_hi_out <= w2_r[odc_pkg::FS_SEL_BIT];
      oc_flag_out       <= flag;
      word1_out         <= w1_r;
      word2_out         <= w2_r;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_ec_on;
    ec_mode;
  endsequence

  a_ec_gate_drive: assert property (s_ec_on |=> ec_gate_drive_out)
    else $error("gate drive not enabled in electrochrome mode");
  a_highside_output_ten_forced: assert property (s_ec_on |=> highside_output_ten_drive_out)
    else $error("highside ten not forced on");
  a_ref_code_map: assert property (w1_we |=> ##1
      ec_ref_code_out == $past(wr_data_in[7:2], 2))
    else $error("reference code not taken from bits 7 to 2");
  a_ecv_no_recov: assert property (ec_mode |-> !g_ch[6].ocr.recov_en)
    else $error("sense recovery active in electrochrome mode");
  a_hb5_pwm_b: assert property (hb_on_in[4] && hb_pwm_i[4] && !pwm_b_in
      |=> !hb_drive_out[4])
    else $error("half bridge five not gated by pwm b");
  a_hb1_pwm_a: assert property (hb_on_in[0] && hb_pwm_i[0] && allow[0] && pwm_a_in
      |=> hb_drive_out[0])
    else $error("half bridge one not on with pwm a high");
  a_fs_select: assert property (w2_we |=> ##1
      full_scale_hi_out == $past(wr_data_in[0], 2))
    else $error("full scale select not following write");
  a_rsvd_zero: assert property (!w1_r[0] && !w2_r[8])
    else $error("reserved bit reads nonzero");
endmodule // odc_ctrl_top

//--- dv/odc_host_model.sv
// partner model: microcontroller writing the two control words
`timescale 1ns/1ps
module odc_host_model
(
  input  wire logic        clk_in,     // system clock
  output logic             wr_en_out,  // write strobe
  output logic             wr_sel_out, // word select
  output logic      [15:0] wr_data_out // write data
);
  // ****************************************************************
  // idle bus at time zero
  // ****************************************************************
  initial
  begin
    wr_en_out   = 1'h0;
    wr_sel_out  = 1'h0;
    wr_data_out = 16'h0000;
  end

  // one strobe a word; reserved bits always sent as zero
  task automatic write_word(input logic sel, input logic [15:0] data);
    logic [15:0] mask;
    mask = sel ? odc_pkg::W2_RSVD_MASK : odc_pkg::W1_RSVD_MASK;
    @(posedge clk_in);
    #1;
    wr_en_out   = 1'h1;
    wr_sel_out  = sel;
    wr_data_out = data & mask;
    @(posedge clk_in);
    #1;
    wr_en_out   = 1'h0;
    // data no longer valid: show the inverse, not a stale copy
    wr_data_out = ~wr_data_out;
  endtask
endmodule // odc_host_model

//--- dv/odc_ctrl_top_test.sv
// testbench: control words, pwm gating and over-current shutdown
`timescale 1ns/1ps
module odc_ctrl_top_test;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic        clk_in = 1'h0;       // 40 MHz clock
  logic        sys_rst_in = 1'h1;   // held at start
  logic        wr_en, wr_sel;       // from host model
  logic [15:0] wr_data, word1, word2;
  logic [5:0]  hb_on = 6'h00;       // half bridge on bits
  logic [5:0]  ec_ref, hb_drive;
  logic        pwm10 = 1'h0;        // highside ten gating
  logic        fast = 1'h0;         // recovery rate
  logic        pwm_a = 1'h0;
  logic        pwm_b = 1'h0;
  logic [6:0]  oc_ev = 7'h00;       // event pulses
  logic [6:0]  oc_clr = 7'h00;      // clear pulses
  logic [6:0]  oc_flag;
  logic        gate, fs_hi, ecv_drv, highside_output_ten_drv;
  logic [15:0] w1 = 16'h0000;       // expected first word
  logic [15:0] w2 = 16'h0000;       // expected second word
  logic [15:0] ca [4] = '{16'h0002, 16'hFFFF, 16'h0500, 16'h00FC};
  logic [15:0] cb [4] = '{16'h0000, 16'hFFFF, 16'h00FE, 16'h0001};
  int          miscompares = 0;
  int          n_compared = 0;
  int          cycles = 0;

  always #12.5 clk_in = ~clk_in;

  odc_host_model host (.clk_in(clk_in), .wr_en_out(wr_en), .wr_sel_out(wr_sel),
    .wr_data_out(wr_data));

  // short recovery periods keep the run brief
  odc_ctrl_top #(.OCR_SLOW_CYC(40), .OCR_FAST_CYC(24)) dut (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .wr_en_in(wr_en), .wr_sel_in(wr_sel),
    .wr_data_in(wr_data), .hb_on_in(hb_on), .highside_output_ten_pwm_en_in(pwm10),
    .ocr_fast_in(fast), .pwm_a_in(pwm_a), .pwm_b_in(pwm_b),
    .oc_event_in(oc_ev), .oc_clr_in(oc_clr), .word1_out(word1),
    .word2_out(word2), .ec_ref_code_out(ec_ref), .ec_gate_drive_out(gate),
    .full_scale_hi_out(fs_hi), .hb_drive_out(hb_drive),
    .ecv_drive_out(ecv_drv), .highside_output_ten_drive_out(highside_output_ten_drv),
    .oc_flag_out(oc_flag));

  // ****************************************************************
  // compare, verdict, hang guard
  // ****************************************************************
  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // run should need under 3000 cycles
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  // ****************************************************************
  // expectations from the gating rules
  // ****************************************************************
  function automatic logic [5:0] exp_hb(input logic [15:0] c2, input logic [5:0] on);
    logic [5:0] r;
    for (int i = 0; i < 6; i++)
      r[i] = on[i] & (~c2[7 - i] | ((i == 4) ? pwm_b : pwm_a));
    return r;
  endfunction

  // shadow keeps reserved bits at zero, as the device stores them
  task automatic wr(input logic sel, input logic [15:0] d);
    host.write_word(sel, d);
    if (sel)
      w2 = d & 16'hFEFF;
    else
      w1 = d & 16'hFFFE;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  task automatic check_all();
    settle();
    check("word1", word1, w1);
    check("word2", word2, w2);
    check("ref_code", {10'h000, ec_ref}, {10'h000, w1[7:2]});
    check("gate", {15'h0000, gate}, {15'h0000, w1[1]});
    check("full_scale", {15'h0000, fs_hi}, {15'h0000, w2[0]});
    check("hb_drive", {10'h000, hb_drive}, {10'h000, exp_hb(w2, hb_on)});
    check("ecv", {15'h0000, ecv_drv}, {15'h0000, w1[8] & (~w2[1] | pwm_a)});
    check("highside_output_ten", {15'h0000, highside_output_ten_drv},
      {15'h0000, w1[1] | (w1[10] & (~pwm10 | pwm_b))});
    check("flags", {9'h000, oc_flag}, 16'h0000);
  endtask

  // idle edge first, so back-to-back pulses never rewrite a strobe in one step
  task automatic pulse(input logic clr, input logic [6:0] m);
    @(posedge clk_in);
    #1;
    if (clr)
      oc_clr = m;
    else
      oc_ev = m;
    @(posedge clk_in);
    #1;
    if (clr)
      oc_clr = 7'h00;
    else
      oc_ev = 7'h00;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    int k;
    void'($urandom(32'hddc2e239));
    repeat (20) @(posedge clk_in);
    #1;
    sys_rst_in = 1'h0;
    check("fs_reset", {15'h0000, fs_hi}, 16'h0000);
    // corner words first, then random words and input levels
    for (int n = 0; n < 44; n++)
    begin
      {hb_on, pwm10, fast, pwm_a, pwm_b} = 10'($urandom);
      if (n < 4)
      begin
        wr(1'h0, ca[n]);
        wr(1'h1, cb[n]);
      end
      else
      begin
        wr(1'h0, 16'($urandom));
        wr(1'h1, 16'($urandom));
      end
      check_all();
      {pwm_a, pwm_b} = ~{pwm_a, pwm_b};
      check_all();
    end
    // mid-run reset must bring full scale select back to zero
    wr(1'h1, 16'h0001);
    check_all();
    sys_rst_in = 1'h1;
    repeat (2) @(posedge clk_in);
    #1;
    sys_rst_in = 1'h0;
    w1 = 16'h0000;
    w2 = 16'h0000;
    check("fs_reset2", {15'h0000, fs_hi}, 16'h0000);
    check("word2_reset", word2, 16'h0000);
    // over-current: output one recovers on the fast period (24 here)
    {hb_on, pwm_a, pwm_b, fast} = {6'h3F, 3'h7};
    wr(1'h0, 16'h0102);   // electrochrome mode, sense lowside on
    wr(1'h1, 16'h8200);   // recovery on output one, sense recovery ignored
    check_all();
    pulse(1'h0, 7'h01);
    // one edge after the event the drive is off whatever the period phase
    @(posedge clk_in);
    #1;
    check("flag0", {9'h000, oc_flag}, 16'h0001);
    check("off0", {15'h0000, hb_drive[0]}, 16'h0000);
    k = 0;
    while (hb_drive[0] !== 1'h1 && k < 200)
    begin
      @(posedge clk_in);
      #1;
      k++;
    end
    check("recovered0", {15'h0000, hb_drive[0]}, 16'h0001);
    check("recov_time", {15'h0000, (k >= 1 && k <= 24)}, 16'h0001);
    check("sticky0", {9'h000, oc_flag}, 16'h0001);
    pulse(1'h1, 7'h01);
    // output two and sense output: phase may allow one recovery, never two
    fast = 1'h0;
    pulse(1'h0, 7'h42);
    @(posedge clk_in);
    #1;
    check("flag1", {9'h000, oc_flag}, 16'h0042);
    check("off1", {14'h0000, hb_drive[1], ecv_drv}, 16'h0000);
    // longer than one slow period (40 here), so any single recovery is spent
    repeat (45) @(posedge clk_in);
    #1;
    pulse(1'h0, 7'h42);
    repeat (90) @(posedge clk_in);
    #1;
    check("latched1", {14'h0000, hb_drive[1], ecv_drv}, 16'h0000);
    pulse(1'h1, 7'h42);
    check_all();
    finish_test();
  end
endmodule // odc_ctrl_top_test
